// ---- rtl/drive_protection_defines.vh ----
`ifndef DRIVE_PROTECTION_DEFINES_VH
`define DRIVE_PROTECTION_DEFINES_VH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define OFS_WARN 12'h000
`define OFS_TRIP 12'h004
`define OFS_STALL 12'h008
`define OFS_IO 12'h00c
`define OFS_MOTOR 12'h010
`define OFS_STATUS 12'h014
`define OFS_IRQ_STAT 12'h018
`define OFS_IRQ_MASK 12'h01c
`define OFS_FAULT_CLR 12'h020

// ---------------------------------------------------------------
// reset values and limits
// ---------------------------------------------------------------
`define WARN_LEVEL_RST 8'h96
`define WARN_LEVEL_MIN 8'h1e
`define WARN_LEVEL_MAX 8'h96
`define WARN_TIME_RST 8'h0a
`define WARN_TIME_MAX 8'h1e
`define TRIP_LEVEL_RST 8'hb4
`define TRIP_LEVEL_MIN 8'h1e
`define TRIP_LEVEL_MAX 8'hc8
`define TRIP_TIME_RST 8'h3c
`define TRIP_TIME_MAX 8'h3c
`define STALL_MASK_RST 3'h3
`define STALL_LEVEL_RST 8'h96
`define STALL_LEVEL_MIN 8'h1e
`define STALL_LEVEL_MAX 8'h96
`define OUT_SEL_RST 5'h0c
`define RELAY_SEL_RST 5'h11
`define IN4_FUNC_RST 5'h03
`define IN5_FUNC_RST 5'h04
`define MOTOR_CUR_RST 16'h0064

// ---------------------------------------------------------------
// selector codes
// ---------------------------------------------------------------
`define SEL_OVERLOAD 5'h05
`define SEL_INV_OVERLOAD 5'h06
`define SEL_STALL 5'h07
`define SEL_FAULT 5'h11
`define FUNC_EXT_TRIP_NO 5'h12
`define FUNC_EXT_TRIP_NC 5'h13

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_HZ 50000000

`endif

// ---- rtl/drive_protection_logic.v ----
// Overview of operation
// - warning level is percent of rated current, 30 to 150, default 150
// - selector code 5 routes overload warning to terminal or relay
// - enabled trip cuts output after current over trip level for trip time
// - accel stall: hold ramp while current above stall level
// - constant speed stall: decelerate while current above stall level
// - decel stall: suspend ramp while link voltage above its limit
// - stall level is percent of rated current, 30 to 150, default 150
// - stall mask bits: 0 accel, 1 constant, 2 decel; default 3
// - selector code 7 shows stall prevention acting
// - stalls may stretch ramps; no forced completion in set time
// - phase-loss select 1 cuts output on lost U, V or W phase
// - input functions 18 and 19 select N.O. and N.C. external trip
// - N.O. external trip input ON shows fault and cuts output
// - N.C. external trip input OFF shows fault and cuts output
// - inverter overload is flagged above inverter rated current; no prevention acts
// - inverter overload trip alarm on selected terminal or relay
// - terminal and relay selectors each pick the driving status item
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "drive_protection_defines.vh"

module drive_protection_logic
#(
    parameter CLK_HZ = `CLK_HZ
)
(
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // measurements, same clock domain
    input wire [15:0] output_current,
    input wire [15:0] inverter_rated_current,
    input wire [2:0] phase_current_present,
    input wire dc_link_over_limit,
    input wire [1:0] ramp_state,
    // input terminals, asynchronous
    input wire input_terminal_4,
    input wire input_terminal_5,
    // ramp and output control
    output reg ramp_hold,
    output reg ramp_force_decel,
    output reg output_off,
    // multi-function outputs
    output reg aux_output_terminal,
    output reg aux_relay_output,
    output wire irq
);

    // ---------------------------------------------------------------
    // ramp states and constants
    // ---------------------------------------------------------------
    localparam RAMP_IDLE = 2'd0;
    localparam RAMP_ACCEL = 2'd1;
    localparam RAMP_CONST = 2'd2;
    localparam RAMP_DECEL = 2'd3;
    localparam integer SEC_CYCLES = CLK_HZ;

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    reg [7:0] overload_warn_level_q;
    reg [7:0] overload_warn_time_q;
    reg overload_trip_enable_q;
    reg [7:0] overload_trip_level_q;
    reg [7:0] overload_trip_time_q;
    reg [2:0] stall_guard_mask_q;
    reg [7:0] stall_guard_level_q;
    reg phase_loss_enable_q;
    reg [4:0] aux_output_select_q;
    reg [4:0] aux_relay_select_q;
    reg [4:0] input4_function_q;
    reg [4:0] input5_function_q;
    reg [15:0] motor_rated_current_q;
    reg [5:0] irq_stat_q;
    reg [5:0] irq_mask_q;
    reg fault_q;
    reg inv_ol_trip_q;
    reg [31:0] sec_cnt_q;
    reg sec_tick_q;
    reg [1:0] in4_sync_q;
    reg [1:0] in5_sync_q;

    wire wr_en = psel & penable & pwrite;
    wire [31:0] wd = pwdata;
    wire fault_clr = wr_en && (paddr == `OFS_FAULT_CLR) && wd[0];

    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // clamp a written percentage into its legal range
    function [7:0] clamp8;
        input [7:0] v;
        input [7:0] lo;
        input [7:0] hi;
        begin
            if (v < lo)
                clamp8 = lo;
            else if (v > hi)
                clamp8 = hi;
            else
                clamp8 = v;
        end
    endfunction

    // current above pct percent of motor rated current
    function above_pct;
        input [15:0] cur;
        input [15:0] rated;
        input [7:0] pct;
        begin
            above_pct = {8'h0, cur} * 24'h64 > {8'h0, rated} * {16'h0, pct};
        end
    endfunction

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overload_warn_level_q <= `WARN_LEVEL_RST;
            overload_warn_time_q <= `WARN_TIME_RST;
            overload_trip_enable_q <= 1'b0;
            overload_trip_level_q <= `TRIP_LEVEL_RST;
            overload_trip_time_q <= `TRIP_TIME_RST;
            stall_guard_mask_q <= `STALL_MASK_RST;
            stall_guard_level_q <= `STALL_LEVEL_RST;
            phase_loss_enable_q <= 1'b0;
            aux_output_select_q <= `OUT_SEL_RST;
            aux_relay_select_q <= `RELAY_SEL_RST;
            input4_function_q <= `IN4_FUNC_RST;
            input5_function_q <= `IN5_FUNC_RST;
            motor_rated_current_q <= `MOTOR_CUR_RST;
            irq_mask_q <= 6'h00;
        end
        else if (wr_en)
        begin
            case (paddr)
                `OFS_WARN:
                begin
                    overload_warn_level_q <= clamp8(wd[7:0],
                        `WARN_LEVEL_MIN, `WARN_LEVEL_MAX);
                    overload_warn_time_q <= (wd[15:8] > `WARN_TIME_MAX) ?
                        `WARN_TIME_MAX : wd[15:8];
                end
                `OFS_TRIP:
                begin
                    overload_trip_level_q <= clamp8(wd[7:0],
                        `TRIP_LEVEL_MIN, `TRIP_LEVEL_MAX);
                    overload_trip_time_q <= (wd[15:8] > `TRIP_TIME_MAX) ?
                        `TRIP_TIME_MAX : wd[15:8];
                    overload_trip_enable_q <= wd[16];
                end
                `OFS_STALL:
                begin
                    stall_guard_level_q <= clamp8(wd[7:0],
                        `STALL_LEVEL_MIN, `STALL_LEVEL_MAX);
                    stall_guard_mask_q <= wd[10:8];
                end
                `OFS_IO:
                begin
                    aux_output_select_q <= wd[4:0];
                    aux_relay_select_q <= wd[12:8];
                    input4_function_q <= wd[20:16];
                    input5_function_q <= wd[28:24];
                    phase_loss_enable_q <= wd[31];
                end
                `OFS_MOTOR:
                    motor_rated_current_q <= wd[15:0];
                `OFS_IRQ_MASK:
                    irq_mask_q <= wd[5:0];
                default:
                    irq_mask_q <= irq_mask_q;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // one-second tick and input synchronisers
    // ---------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sec_cnt_q <= 32'h0;
            sec_tick_q <= 1'b0;
            in4_sync_q <= 2'b00;
            in5_sync_q <= 2'b00;
        end
        else
        begin
            sec_tick_q <= (sec_cnt_q == SEC_CYCLES - 1);
            sec_cnt_q <= (sec_cnt_q == SEC_CYCLES - 1) ?
                32'h0 : sec_cnt_q + 32'h1;
            in4_sync_q <= {in4_sync_q[0], input_terminal_4};
            in5_sync_q <= {in5_sync_q[0], input_terminal_5};
        end
    end

    // ---------------------------------------------------------------
    // detection
    // ---------------------------------------------------------------
    wire over_warn = above_pct(output_current, motor_rated_current_q,
        overload_warn_level_q);
    wire over_trip = above_pct(output_current, motor_rated_current_q,
        overload_trip_level_q);
    wire over_stall = above_pct(output_current, motor_rated_current_q,
        stall_guard_level_q);
    wire inv_over = output_current > inverter_rated_current;
    wire warn_hit;
    wire trip_hit;

    level_timer warn_timer
    (
        .pclk(pclk),
        .presetn(presetn),
        .sec_tick(sec_tick_q),
        .active(over_warn),
        .limit_sec(overload_warn_time_q),
        .expired(warn_hit)
    );

    level_timer trip_timer
    (
        .pclk(pclk),
        .presetn(presetn),
        .sec_tick(sec_tick_q),
        .active(over_trip & overload_trip_enable_q),
        .limit_sec(overload_trip_time_q),
        .expired(trip_hit)
    );

    // an input may carry either external trip function
    function ext_trip;
        input [4:0] func;
        input level;
        begin
            ext_trip = ((func == `FUNC_EXT_TRIP_NO) && level) ||
                ((func == `FUNC_EXT_TRIP_NC) && !level);
        end
    endfunction

    wire ext_hit = ext_trip(input4_function_q, in4_sync_q[1]) |
        ext_trip(input5_function_q, in5_sync_q[1]);
    wire phase_hit = phase_loss_enable_q &&
        (phase_current_present != 3'b111) && (ramp_state != RAMP_IDLE);

    // ---------------------------------------------------------------
    // stall prevention; ramp is left to finish in its own time
    // ---------------------------------------------------------------
    reg hold_d;
    reg decel_d;
    always @*
    begin
        hold_d = 1'b0;
        decel_d = 1'b0;
        case (ramp_state)
            RAMP_ACCEL:
                hold_d = stall_guard_mask_q[0] & over_stall;
            RAMP_CONST:
                decel_d = stall_guard_mask_q[1] & over_stall;
            RAMP_DECEL:
                hold_d = stall_guard_mask_q[2] & dc_link_over_limit;
            default:
                hold_d = 1'b0;
        endcase
    end
    wire stall_act = hold_d | decel_d;

    // ---------------------------------------------------------------
    // faults, trips and interrupts
    // ---------------------------------------------------------------
    wire trip_any = trip_hit | ext_hit | phase_hit;
    wire [5:0] events = {inv_over, phase_hit, ext_hit, trip_hit,
        stall_act, warn_hit};
    wire [5:0] stat_clr = (wr_en && paddr == `OFS_IRQ_STAT) ?
        wd[5:0] : 6'h00;

    // output selector decode shared by terminal and relay
    function sel_out;
        input [4:0] sel;
        input warn;
        input inv;
        input stall;
        input flt;
        begin
            case (sel)
                `SEL_OVERLOAD: sel_out = warn;
                `SEL_INV_OVERLOAD: sel_out = inv;
                `SEL_STALL: sel_out = stall;
                `SEL_FAULT: sel_out = flt;
                default: sel_out = 1'b0;
            endcase
        end
    endfunction

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_q <= 1'b0;
            inv_ol_trip_q <= 1'b0;
            irq_stat_q <= 6'h00;
            output_off <= 1'b0;
            ramp_hold <= 1'b0;
            ramp_force_decel <= 1'b0;
            aux_output_terminal <= 1'b0;
            aux_relay_output <= 1'b0;
        end
        else
        begin
            // set wins over a same-cycle clear
            irq_stat_q <= (irq_stat_q & ~stat_clr) | events;
            // faults latch until cleared and the cause is gone
            fault_q <= trip_any | (fault_q & ~fault_clr);
            inv_ol_trip_q <= inv_over | (inv_ol_trip_q & ~fault_clr);
            output_off <= trip_any | (fault_q & ~fault_clr);
            ramp_hold <= hold_d;
            ramp_force_decel <= decel_d;
            aux_output_terminal <= sel_out(aux_output_select_q, warn_hit,
                inv_ol_trip_q, stall_act, fault_q);
            aux_relay_output <= sel_out(aux_relay_select_q, warn_hit,
                inv_ol_trip_q, stall_act, fault_q);
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    always @*
    begin
        case (paddr)
            `OFS_WARN: prdata = {16'h0, overload_warn_time_q,
                overload_warn_level_q};
            `OFS_TRIP: prdata = {15'h0, overload_trip_enable_q,
                overload_trip_time_q, overload_trip_level_q};
            `OFS_STALL: prdata = {21'h0, stall_guard_mask_q,
                stall_guard_level_q};
            `OFS_IO: prdata = {phase_loss_enable_q, 2'h0, input5_function_q,
                3'h0, input4_function_q, 3'h0, aux_relay_select_q, 3'h0,
                aux_output_select_q};
            `OFS_MOTOR: prdata = {16'h0, motor_rated_current_q};
            `OFS_STATUS: prdata = {24'h0, inv_ol_trip_q, fault_q,
                output_off, stall_act, trip_hit, warn_hit, ext_hit,
                phase_hit};
            `OFS_IRQ_STAT: prdata = {26'h0, irq_stat_q};
            `OFS_IRQ_MASK: prdata = {26'h0, irq_mask_q};
            default: prdata = 32'h0;
        endcase
    end

endmodule

`default_nettype wire

// ---- rtl/level_timer.v ----
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// persistence timer: counts whole seconds of a level
// ---------------------------------------------------------------
module level_timer
(
    // clock and reset
    input wire pclk,
    input wire presetn,
    // controls
    input wire sec_tick,
    input wire active,
    input wire [7:0] limit_sec,
    // result
    output reg expired
);

    reg [7:0] count_q;

    // any dip in the level restarts the count: the time is continuous
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= 8'h00;
            expired <= 1'b0;
        end
        else if (!active)
        begin
            count_q <= 8'h00;
            expired <= 1'b0;
        end
        else if (count_q >= limit_sec)
        begin
            expired <= 1'b1;
        end
        else if (sec_tick)
        begin
            count_q <= count_q + 8'h01;
        end
    end

endmodule

`default_nettype wire

// ---- tb/drive_protection_logic_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "drive_protection_defines.vh"

module drive_protection_logic_chk (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // measurements
    input wire logic [15:0] output_current,
    input wire logic dc_link_over_limit,
    input wire logic [1:0] ramp_state,
    // controls
    input wire logic ramp_hold,
    input wire logic ramp_force_decel,
    input wire logic output_off
);
    // -----------------
    // ramp and trip checks
    // -----------------
    logic clr;
    // the latch drops on the clock edge that samples a clear write, once the cause is gone
    assign clr = psel && penable && pwrite && paddr == `OFS_FAULT_CLR
        && pwdata[0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_HOLD_PHASE: assert property (ramp_hold |->
        $past(ramp_state) == 2'd1 || $past(ramp_state) == 2'd3)
        else $error("hold outside accel or decel");
    AST_ACCEL_CAUSE: assert property (
        ramp_hold && $past(ramp_state) == 2'd1 |-> $past(output_current) != 0)
        else $error("accel hold without current");
    AST_DECEL_CAUSE: assert property (
        ramp_hold && $past(ramp_state) == 2'd3 |-> $past(dc_link_over_limit))
        else $error("decel hold without link limit");
    AST_FORCE_CAUSE: assert property (ramp_force_decel |->
        $past(ramp_state) == 2'd2 && $past(output_current) != 0)
        else $error("forced decel without cause");
    AST_ONE_ACTION: assert property (!(ramp_hold && ramp_force_decel))
        else $error("hold and decel together");
    AST_IDLE_QUIET: assert property (ramp_state == 2'd0 |=>
        !ramp_hold && !ramp_force_decel)
        else $error("ramp action while idle");
    AST_OFF_LATCH: assert property (output_off && !clr && !$past(clr)
        && !$past(clr, 2) |=> output_off)
        else $error("output cut released without clear");
    AST_STATUS_OFF: assert property (psel && penable && !pwrite
        && paddr == `OFS_STATUS |-> prdata[5] == output_off)
        else $error("status disagrees with output cut");
endmodule

`default_nettype wire

// ---- tb/drive_protection_logic_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "drive_protection_defines.vh"

module drive_protection_logic_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic dc, in4, in5, hold, decel, off, ao, ro, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] cur;
    logic [7:0] load;
    logic [2:0] ph, open_ph;
    logic [1:0] rs;
    integer miscompares = 0;
    integer checked = 0;

    drive_protection_logic #(.CLK_HZ(100)) i_drive_protection_logic (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .output_current(cur),
        .inverter_rated_current(16'h0078), .phase_current_present(ph),
        .dc_link_over_limit(dc), .ramp_state(rs), .input_terminal_4(in4),
        .input_terminal_5(in5), .ramp_hold(hold), .ramp_force_decel(decel),
        .output_off(off), .aux_output_terminal(ao), .aux_relay_output(ro),
        .irq(irq));
    motor_model i_motor_model (.pclk(pclk), .output_off(off),
        .load_pct(load), .open_phase(open_ph), .rated(16'h0064),
        .output_current(cur), .phase_current_present(ph));

    // -----------------
    // helpers
    // -----------------
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    function logic pick(input integer k);
        case (k)
            0: pick = ao;
            1: pick = ro;
            2: pick = off;
            3: pick = hold;
            4: pick = decel;
            default: pick = irq;
        endcase
    endfunction

    task finish_test;
        begin
            $display("checked %0d miscompares %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp)
            begin
                miscompares = miscompares + 1;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // one transfer; read data lands in r
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do
            begin
                @(posedge pclk);
                n = n + 1;
            end
            while (pready !== 1'b1 && n < 16);
            r = prdata;
            chk({30'h0, pslverr, pready}, 32'h1);
            if (n >= 16)
                finish_test;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task wait_val(input integer k, input logic v, input integer n);
        integer i;
        begin
            #1;
            for (i = 0; i < n && pick(k) !== v; i = i + 1)
            begin
                @(posedge pclk);
                #1;
            end
            chk({31'h0, pick(k)}, {31'h0, v});
            if (pick(k) !== v)
                finish_test;
        end
    endtask

    task hold_val(input integer k, input logic v, input integer n);
        repeat (n)
        begin
            @(posedge pclk);
            #1;
            chk({31'h0, pick(k)}, {31'h0, v});
        end
    endtask

    // -----------------
    // scenarios
    // -----------------
    task t_regs;
        logic [11:0] a [0:8];
        logic [31:0] w [0:8];
        logic [31:0] e [0:8];
        integer i;
        begin
            a = '{`OFS_WARN, `OFS_TRIP, `OFS_STALL, `OFS_IO, `OFS_MOTOR,
                12'h040, `OFS_WARN, `OFS_TRIP, `OFS_STALL};
            w = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h64, 32'hffffffff,
                32'h00000a0a, 32'h00003cff, 32'h00000305};
            e = '{32'h00000a96, 32'h00003cb4, 32'h00000396, 32'h0403110c,
                32'h64, 32'h0, 32'h00000a1e, 32'h00003cc8, 32'h0000031e};
            for (i = 0; i < 9; i = i + 1)
            begin
                if (i > 3)
                    apb(a[i], 1'b1, w[i]);
                apb(a[i], 1'b0, 32'h0);
                chk(r, e[i]);
            end
            $display("regs done");
        end
    endtask

    task t_warn;
        begin
            apb(`OFS_WARN, 1'b1, 32'h00000264);
            apb(`OFS_IO, 1'b1, 32'h04030505);
            apb(`OFS_IRQ_MASK, 1'b1, 32'h1);
            @(posedge pclk);
            load <= 8'h6e;
            hold_val(0, 1'b0, 95);
            wait_val(0, 1'b1, 220);
            wait_val(1, 1'b1, 2);
            wait_val(5, 1'b1, 2);
            apb(`OFS_IRQ_STAT, 1'b1, 32'h1);
            hold_val(5, 1'b1, 3);
            @(posedge pclk);
            load <= 8'h00;
            wait_val(0, 1'b0, 10);
            apb(`OFS_IRQ_STAT, 1'b1, 32'h1);
            wait_val(5, 1'b0, 4);
            $display("warn done");
        end
    endtask

    // case nibbles: state, mask, {load, link}, {decel, hold}
    task t_stall;
        logic [15:0] t [0:7];
        logic [15:0] c;
        integer i;
        begin
            t = '{16'h1121, 16'h1620, 16'h1100, 16'h2222, 16'h2520,
                16'h3411, 16'h3400, 16'h3310};
            apb(`OFS_IRQ_MASK, 1'b1, 32'h0);
            apb(`OFS_IO, 1'b1, 32'h04031107);
            for (i = 0; i < 8; i = i + 1)
            begin
                c = t[i];
                apb(`OFS_STALL, 1'b1, {21'h0, c[10:8], 8'h64});
                @(posedge pclk);
                rs <= c[13:12];
                dc <= c[4];
                load <= c[5] ? 8'h6e : 8'h00;
                wait_val(3, c[0], 10);
                wait_val(4, c[1], 10);
                wait_val(0, |c[1:0], 10);
                hold_val(3, c[0], 20);
            end
            @(posedge pclk);
            rs <= 2'h0;
            dc <= 1'b0;
            load <= 8'h00;
            hold_val(5, 1'b0, 3);
            apb(`OFS_IRQ_MASK, 1'b1, 32'h2);
            wait_val(5, 1'b1, 3);
            apb(`OFS_IRQ_STAT, 1'b1, 32'h2);
            wait_val(5, 1'b0, 4);
            apb(`OFS_IRQ_MASK, 1'b1, 32'h0);
            $display("stall done");
        end
    endtask

    task clear_fault;
        begin
            hold_val(2, 1'b1, 4);
            apb(`OFS_FAULT_CLR, 1'b1, 32'h1);
            wait_val(2, 1'b0, 10);
        end
    endtask

    task t_trip;
        begin
            apb(`OFS_TRIP, 1'b1, 32'h00000164);
            @(posedge pclk);
            load <= 8'h6e;
            hold_val(2, 1'b0, 230);
            apb(`OFS_TRIP, 1'b1, 32'h00010164);
            wait_val(2, 1'b1, 230);
            @(posedge pclk);
            load <= 8'h00;
            apb(`OFS_TRIP, 1'b1, 32'h00000164);
            clear_fault;
            $display("trip done");
        end
    endtask

    task t_ext;
        begin
            apb(`OFS_IO, 1'b1, 32'h1312110c);
            @(posedge pclk);
            in4 <= 1'b1;
            wait_val(2, 1'b1, 10);
            wait_val(1, 1'b1, 4);
            apb(`OFS_STATUS, 1'b0, 32'h0);
            chk(r & 32'h62, 32'h62);
            @(posedge pclk);
            in4 <= 1'b0;
            clear_fault;
            @(posedge pclk);
            in5 <= 1'b0;
            wait_val(2, 1'b1, 10);
            @(posedge pclk);
            in5 <= 1'b1;
            clear_fault;
            $display("ext done");
        end
    endtask

    task t_phase;
        begin
            apb(`OFS_IO, 1'b1, 32'h0403110c);
            @(posedge pclk);
            rs <= 2'h2;
            load <= 8'h32;
            open_ph <= 3'h2;
            hold_val(2, 1'b0, 20);
            apb(`OFS_IO, 1'b1, 32'h8403110c);
            wait_val(2, 1'b1, 10);
            @(posedge pclk);
            rs <= 2'h0;
            open_ph <= 3'h0;
            load <= 8'h00;
            apb(`OFS_IO, 1'b1, 32'h0403110c);
            clear_fault;
            $display("phase done");
        end
    endtask

    task t_inv;
        begin
            apb(`OFS_IO, 1'b1, 32'h04030606);
            @(posedge pclk);
            load <= 8'h82;
            wait_val(0, 1'b1, 10);
            wait_val(1, 1'b1, 2);
            @(posedge pclk);
            load <= 8'h00;
            hold_val(0, 1'b1, 5);
            $display("inv done");
        end
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        load = 8'h00;
        open_ph = 3'h0;
        rs = 2'h0;
        dc = 1'b0;
        in4 = 1'b0;
        in5 = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_warn;
        t_stall;
        t_trip;
        t_ext;
        t_phase;
        t_inv;
        finish_test;
    end
endmodule

bind drive_protection_logic drive_protection_logic_chk
    i_drive_protection_logic_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .output_current(output_current),
    .dc_link_over_limit(dc_link_over_limit), .ramp_state(ramp_state),
    .ramp_hold(ramp_hold), .ramp_force_decel(ramp_force_decel),
    .output_off(output_off));

`default_nettype wire

// ---- tb/motor_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module motor_model (
    // drive side
    input wire logic pclk,
    input wire logic output_off,
    // bench commands
    input wire logic [7:0] load_pct,
    input wire logic [2:0] open_phase,
    input wire logic [15:0] rated,
    // measured back
    output var logic [15:0] output_current,
    output var logic [2:0] phase_current_present
);
    // -----------------
    // load response
    // -----------------
    // no current flows once the drive cuts its output
    always @(posedge pclk)
    begin
        output_current <= output_off ? 16'h0 : 16'((rated * load_pct) / 100);
        phase_current_present <= output_off ? 3'h0 : ~open_phase;
    end
endmodule

`default_nettype wire
